/* hdl/fsi_indicators.sv */
`timescale 1ns/1ps

module fsi_indicators #(
  parameter int unsigned TickCycles = (fsi_pkg::TICK_MS * 1000000) / fsi_pkg::CLK_PERIOD_NS
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic masterReqValid,
  input wire fsi_pkg::fsi_state_t masterReqState,
  input wire logic appReqValid,
  input wire fsi_pkg::fsi_state_t appReqState,
  input wire logic fatalEvent,
  input wire logic wdogExpire,
  input wire logic appException,
  input wire logic bootError,
  input wire logic linkUp,
  input wire logic rxActivity,
  input wire logic restrictSizes,
  input wire logic sizeLoad,
  input wire logic [8:0] inBytesCfg,
  input wire logic [8:0] outBytesCfg,
  input wire logic mapReq,
  input wire logic mapOutDir,
  input wire logic [11:0] mapBitIdx,
  output fsi_pkg::fsi_leds_t leds,
  output fsi_pkg::fsi_svc_t svc,
  output fsi_pkg::fsi_state_t commState,
  output fsi_pkg::fsi_err_t errClass,
  output logic reqRefused,
  output logic [8:0] inBytes,
  output logic [8:0] outBytes,
  output logic [15:0] inIoLast,
  output logic [15:0] outIoLast,
  output logic mapValid,
  output logic [15:0] mapIoNum
);

  localparam logic [31:0] TickMax = 32'(TickCycles - 1);

  logic [31:0] tickCnt_q;
  logic tick_q;
  logic [6:0] phase_q;
  logic [6:0] singlePh_q;
  logic [6:0] doublePh_q;
  fsi_pkg::fsi_state_t state_q;
  fsi_pkg::fsi_state_t state_d;
  logic fatal_q;
  logic invalid_q;
  logic unsol_q;
  logic wdog_q;
  logic actSeen_q;
  logic actShown_q;
  logic [8:0] inBytes_q;
  logic [8:0] outBytes_q;
  logic reqOk;
  logic sizesOk;
  logic appOk;
  fsi_pkg::fsi_err_t errNow;
  logic blinkOn;
  logic singleOn;
  logic doubleOn;
  logic flickOn;

  // free-running timebase; every pattern derives from the same tick so they stay in step
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else if (clkEn)
    begin
      tick_q <= (tickCnt_q == TickMax);
      if (tickCnt_q == TickMax)
        tickCnt_q <= 32'h00000000;
      else
        tickCnt_q <= tickCnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      phase_q <= 7'h00;
      singlePh_q <= 7'h00;
      doublePh_q <= 7'h00;
    end
    else if (clkEn && tick_q)
    begin
      phase_q <= (phase_q == fsi_pkg::PHASE_WRAP) ? 7'h00 : phase_q + 7'h01;
      singlePh_q <= (singlePh_q == fsi_pkg::SINGLE_PERIOD - 7'h01) ? 7'h00 : singlePh_q + 7'h01;
      doublePh_q <= (doublePh_q == fsi_pkg::DOUBLE_PERIOD - 7'h01) ? 7'h00 : doublePh_q + 7'h01;
    end
  end

  // blink: 4 ticks on, 4 off; flashes: 4-tick pulses; flicker: one tick each way
  always_comb
  begin
    blinkOn = ~phase_q[2];
    flickOn = phase_q[0];
    singleOn = singlePh_q < fsi_pkg::FLASH_TICKS;
    doubleOn = (doublePh_q < fsi_pkg::FLASH_TICKS) ||
               ((doublePh_q >= 7'h08) && (doublePh_q < 7'h08 + fsi_pkg::FLASH_TICKS));
  end

  // a size set counts as valid settings only if it is legal for the attached master
  function automatic logic sizeLegal(input logic [8:0] sz, input logic onlyPow);
    logic pow;
    pow = (sz == fsi_pkg::SIZE_R32) || (sz == fsi_pkg::SIZE_R64) ||
          (sz == fsi_pkg::SIZE_R128) || (sz == fsi_pkg::SIZE_R256);
    sizeLegal = onlyPow ? pow : ((sz != 9'h000) && (sz <= fsi_pkg::SIZE_MAX));
  endfunction

  always_comb
  begin
    sizesOk = sizeLegal(inBytes_q, restrictSizes) && sizeLegal(outBytes_q, restrictSizes);
  end

  // legal master-driven transitions; anything past pre-operational needs valid sizes
  always_comb
  begin
    reqOk = 1'b0;
    case (state_q)
      fsi_pkg::ST_INIT:
        reqOk = (masterReqState == fsi_pkg::ST_INIT) || (masterReqState == fsi_pkg::ST_PREOP) ||
                (masterReqState == fsi_pkg::ST_BOOT);
      fsi_pkg::ST_BOOT:
        reqOk = (masterReqState == fsi_pkg::ST_INIT) || (masterReqState == fsi_pkg::ST_BOOT);
      fsi_pkg::ST_PREOP:
        reqOk = (masterReqState == fsi_pkg::ST_INIT) || (masterReqState == fsi_pkg::ST_PREOP) ||
                ((masterReqState == fsi_pkg::ST_SAFEOP) && sizesOk);
      fsi_pkg::ST_SAFEOP:
        reqOk = (masterReqState != fsi_pkg::ST_BOOT) &&
                ((masterReqState != fsi_pkg::ST_OP) || sizesOk);
      fsi_pkg::ST_OP:
        reqOk = (masterReqState != fsi_pkg::ST_BOOT);
      default:
        reqOk = 1'b0;
    endcase
  end

  // the application may only step itself down, never up
  always_comb
  begin
    appOk = appReqValid && (appReqState != fsi_pkg::ST_BOOT) && (state_q != fsi_pkg::ST_BOOT) &&
            (appReqState < state_q) && (appReqState != state_q);
  end

  always_comb
  begin
    state_d = state_q;
    if (masterReqValid && reqOk)
      state_d = masterReqState;
    if (appOk)
      state_d = appReqState;
    else if (wdogExpire && (state_q == fsi_pkg::ST_OP))
      state_d = fsi_pkg::ST_SAFEOP;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= fsi_pkg::ST_INIT;
    else if (clkEn && !fatal_q)
      state_q <= state_d;
  end

  // fatal holds until reset: nothing but rst_n brings the bus interface back
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      fatal_q <= 1'b0;
    else if (clkEn && fatalEvent)
      fatal_q <= 1'b1;
  end

  // error flags: a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      invalid_q <= 1'b0;
      unsol_q <= 1'b0;
      wdog_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (masterReqValid && !reqOk)
        invalid_q <= 1'b1;
      else if (masterReqValid)
        invalid_q <= 1'b0;
      if (appOk)
        unsol_q <= 1'b1;
      else if (masterReqValid && reqOk)
        unsol_q <= 1'b0;
      if (wdogExpire)
        wdog_q <= 1'b1;
      else if (masterReqValid && reqOk)
        wdog_q <= 1'b0;
    end
  end

  // traffic is judged per tick so single frames still give a visible flicker
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      actSeen_q <= 1'b0;
      actShown_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (tick_q)
      begin
        actShown_q <= actSeen_q | rxActivity;
        actSeen_q <= rxActivity;
      end
      else if (rxActivity)
        actSeen_q <= 1'b1;
    end
  end

  // sizes only change in init, as a new size needs the link to restart
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      inBytes_q <= fsi_pkg::SIZE_DEFAULT;
      outBytes_q <= fsi_pkg::SIZE_DEFAULT;
    end
    else if (clkEn && sizeLoad && (state_q == fsi_pkg::ST_INIT))
    begin
      inBytes_q <= inBytesCfg;
      outBytes_q <= outBytesCfg;
    end
  end

  // highest severity shown first
  always_comb
  begin
    if (fatal_q)
      errNow = fsi_pkg::ERR_FATAL;
    else if (bootError)
      errNow = fsi_pkg::ERR_BOOT;
    else if (appException)
      errNow = fsi_pkg::ERR_EXCEPT;
    else if (wdog_q)
      errNow = fsi_pkg::ERR_WDOG;
    else if (unsol_q)
      errNow = fsi_pkg::ERR_UNSOL;
    else if (invalid_q)
      errNow = fsi_pkg::ERR_INVALID;
    else
      errNow = fsi_pkg::ERR_NONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      leds <= '0;
      errClass <= fsi_pkg::ERR_NONE;
    end
    else if (clkEn)
    begin
      errClass <= errNow;
      if (fatal_q)
      begin
        leds.runGreen <= 1'b0;
        leds.runRed <= 1'b1;
      end
      else
      begin
        leds.runRed <= 1'b0;
        case (state_q)
          fsi_pkg::ST_INIT: leds.runGreen <= 1'b0;
          fsi_pkg::ST_OP: leds.runGreen <= 1'b1;
          fsi_pkg::ST_PREOP: leds.runGreen <= blinkOn;
          fsi_pkg::ST_SAFEOP: leds.runGreen <= singleOn;
          fsi_pkg::ST_BOOT: leds.runGreen <= flickOn;
          default: leds.runGreen <= 1'b0;
        endcase
      end
      case (errNow)
        fsi_pkg::ERR_FATAL: leds.errRed <= 1'b1;
        fsi_pkg::ERR_BOOT: leds.errRed <= flickOn;
        fsi_pkg::ERR_EXCEPT: leds.errRed <= 1'b1;
        fsi_pkg::ERR_WDOG: leds.errRed <= doubleOn;
        fsi_pkg::ERR_UNSOL: leds.errRed <= singleOn;
        fsi_pkg::ERR_INVALID: leds.errRed <= blinkOn;
        default: leds.errRed <= 1'b0;
      endcase
      if (!linkUp)
        leds.linkGreen <= 1'b0;
      else if (actShown_q)
        leds.linkGreen <= flickOn;
      else
        leds.linkGreen <= 1'b1;
    end
  end

  // service gating per state; a fatal event shuts every service off
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      svc <= '0;
      commState <= fsi_pkg::ST_INIT;
      reqRefused <= 1'b0;
    end
    else if (clkEn)
    begin
      commState <= state_q;
      reqRefused <= masterReqValid && !reqOk && !fatal_q;
      svc.busPassive <= fatal_q;
      svc.sdoAllow <= !fatal_q && ((state_q == fsi_pkg::ST_PREOP) || (state_q == fsi_pkg::ST_SAFEOP) ||
                                   (state_q == fsi_pkg::ST_OP));
      svc.pdoTxAllow <= !fatal_q && ((state_q == fsi_pkg::ST_SAFEOP) ||
                                     (state_q == fsi_pkg::ST_OP));
      svc.pdoOutCtrl <= !fatal_q && (state_q == fsi_pkg::ST_OP);
    end
  end

  // io numbering: one number per process-data bit, from the io base upward
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      inBytes <= fsi_pkg::SIZE_DEFAULT;
      outBytes <= fsi_pkg::SIZE_DEFAULT;
      inIoLast <= 16'h0000;
      outIoLast <= 16'h0000;
      mapValid <= 1'b0;
      mapIoNum <= 16'h0000;
    end
    else if (clkEn)
    begin
      inBytes <= inBytes_q;
      outBytes <= outBytes_q;
      inIoLast <= fsi_pkg::IO_BASE + {4'h0, inBytes_q, 3'h0} - 16'h0001;
      outIoLast <= fsi_pkg::IO_BASE + {4'h0, outBytes_q, 3'h0} - 16'h0001;
      mapValid <= mapReq && (mapBitIdx < (mapOutDir ? {outBytes_q, 3'h0} : {inBytes_q, 3'h0}));
      mapIoNum <= fsi_pkg::IO_BASE + {4'h0, mapBitIdx};
    end
  end

endmodule

/* hdl/fsi_pkg.sv */
package fsi_pkg;

  // communication states, binary codes written out
  typedef enum logic [2:0]
  {
    ST_INIT   = 3'b000,
    ST_PREOP  = 3'b001,
    ST_BOOT   = 3'b010,
    ST_SAFEOP = 3'b011,
    ST_OP     = 3'b100
  } fsi_state_t;

  // error indication classes, lowest code is "no error"
  typedef enum logic [2:0]
  {
    ERR_NONE    = 3'b000,
    ERR_INVALID = 3'b001,
    ERR_UNSOL   = 3'b010,
    ERR_WDOG    = 3'b011,
    ERR_EXCEPT  = 3'b100,
    ERR_BOOT    = 3'b101,
    ERR_FATAL   = 3'b110
  } fsi_err_t;

  typedef struct packed
  {
    logic runGreen;
    logic runRed;
    logic errRed;
    logic linkGreen;
  } fsi_leds_t;

  typedef struct packed
  {
    logic sdoAllow;
    logic pdoTxAllow;
    logic pdoOutCtrl;
    logic busPassive;
  } fsi_svc_t;

  // timebase
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_MS = 50;
  localparam logic [6:0] PHASE_WRAP = 7'h5F;
  localparam logic [6:0] SINGLE_PERIOD = 7'h18;
  localparam logic [6:0] DOUBLE_PERIOD = 7'h20;
  localparam logic [6:0] FLASH_TICKS = 7'h04;

  // process-data sizing
  localparam logic [8:0] SIZE_DEFAULT = 9'h020;
  localparam logic [8:0] SIZE_MAX = 9'h100;
  localparam logic [8:0] SIZE_R32 = 9'h020;
  localparam logic [8:0] SIZE_R64 = 9'h040;
  localparam logic [8:0] SIZE_R128 = 9'h080;
  localparam logic [8:0] SIZE_R256 = 9'h100;
  localparam logic [15:0] IO_BASE = 16'h0200;

endpackage

/* tb/fsi_indicators_checker.sv */
`timescale 1ns/1ps
module fsi_indicators_checker
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fatalEvent,
  input wire logic linkUp,
  input wire logic [11:0] mapBitIdx,
  input wire fsi_pkg::fsi_leds_t leds,
  input wire fsi_pkg::fsi_svc_t svc,
  input wire fsi_pkg::fsi_state_t commState,
  input wire fsi_pkg::fsi_err_t errClass,
  input wire logic reqRefused,
  input wire logic [8:0] inBytes,
  input wire logic [8:0] outBytes,
  input wire logic mapValid,
  input wire logic [15:0] mapIoNum
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_init_run_dark: assert property (commState == fsi_pkg::ST_INIT && $past(commState) == fsi_pkg::ST_INIT
    |-> !leds.runGreen) else $error("run lit in init");
  a_op_run_steady: assert property (commState == fsi_pkg::ST_OP && $past(commState) == fsi_pkg::ST_OP
    && !svc.busPassive |-> leds.runGreen) else $error("run not steady in op");
  a_fatal_both_red: assert property (fatalEvent |-> ##[1:3] (leds.runRed && leds.errRed && svc.busPassive))
    else $error("fatal not shown");
  a_no_err_dark: assert property (errClass == fsi_pkg::ERR_NONE && $past(errClass) == fsi_pkg::ERR_NONE
    |-> !leds.errRed) else $error("error lit without error");
  a_link_down_dark: assert property (!linkUp && !$past(linkUp) && !$past(linkUp, 2) |-> !leds.linkGreen)
    else $error("link lit without link");
  a_preop_svc_gate: assert property (commState == fsi_pkg::ST_PREOP && !svc.busPassive
    |-> svc.sdoAllow && !svc.pdoTxAllow && !svc.pdoOutCtrl) else $error("preop services wrong");
  a_safeop_svc_gate: assert property (commState == fsi_pkg::ST_SAFEOP && !svc.busPassive
    |-> svc.sdoAllow && svc.pdoTxAllow && !svc.pdoOutCtrl) else $error("safeop services wrong");
  a_op_svc_gate: assert property (commState == fsi_pkg::ST_OP && !svc.busPassive
    |-> svc.sdoAllow && svc.pdoTxAllow && svc.pdoOutCtrl) else $error("op services wrong");
  a_size_default_val: assert property (!$past(rst_n)
    |-> inBytes == fsi_pkg::SIZE_DEFAULT && outBytes == fsi_pkg::SIZE_DEFAULT) else $error("size default wrong");
  a_map_io_num: assert property (mapValid |-> mapIoNum == fsi_pkg::IO_BASE + {4'h0, $past(mapBitIdx)})
    else $error("io number wrong");
  c_map: cover property (mapValid);
  c_refuse: cover property (reqRefused);
  c_fatal: cover property (leds.runRed);
endmodule
bind fsi_indicators fsi_indicators_checker chk (.clk_sys, .rst_n, .fatalEvent, .linkUp, .mapBitIdx, .leds, .svc,
  .commState, .errClass, .reqRefused, .inBytes, .outBytes, .mapValid, .mapIoNum);

/* tb/fsi_indicators_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module fsi_indicators_test;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic clkEn = 1'h1;
  logic appReqValid = 1'h0, fatalEvent = 1'h0, wdogExpire = 1'h0, appException = 1'h0, bootError = 1'h0;
  logic linkUp = 1'h0, rxActivity = 1'h0, restrictSizes = 1'h0, sizeLoad = 1'h0, mapReq = 1'h0, mapOutDir = 1'h0;
  logic [8:0] inBytesCfg = 9'h020, outBytesCfg = 9'h020;
  logic [11:0] mapBitIdx = 12'h000;
  fsi_pkg::fsi_state_t appReqState = fsi_pkg::ST_INIT;
  logic masterReqValid, reqRefused, mapValid;
  fsi_pkg::fsi_state_t masterReqState, commState;
  fsi_pkg::fsi_leds_t leds;
  fsi_pkg::fsi_svc_t svc;
  fsi_pkg::fsi_err_t errClass;
  logic [8:0] inBytes, outBytes;
  logic [15:0] inIoLast, outIoLast, mapIoNum;
  int n_errors = 0, total_checks = 0;
  // short tick keeps each 96-tick pattern frame at 384 cycles
  fsi_indicators #(.TickCycles(4)) dut (.clk_sys, .rst_n, .clkEn, .masterReqValid, .masterReqState, .appReqValid,
    .appReqState, .fatalEvent, .wdogExpire, .appException, .bootError, .linkUp, .rxActivity, .restrictSizes,
    .sizeLoad, .inBytesCfg, .outBytesCfg, .mapReq, .mapOutDir, .mapBitIdx, .leds, .svc, .commState, .errClass,
    .reqRefused, .inBytes, .outBytes, .inIoLast, .outIoLast, .mapValid, .mapIoNum);
  fsi_master_model mst (.clk_sys, .masterReqValid, .masterReqState);
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'h1;
    @(negedge clk_sys);
    s = 1'h0;
  endtask
  // lit cycles over one full frame; frame is a whole number of every pattern period
  task automatic patt(input int b, input logic [9:0] e);
    logic [9:0] c;
    c = 10'h000;
    repeat (8) @(negedge clk_sys);
    repeat (384)
    begin
      @(negedge clk_sys);
      c = c + leds[b];
    end
    `CHK("pattern", e, c)
  endtask
  task automatic mreq(input fsi_pkg::fsi_state_t s, input logic [3:0] r);
    logic [3:0] c;
    c = 4'h0;
    mst.request(s);
    // the refusal pulse already stands when the request is released
    repeat (4)
    begin
      c = c + reqRefused;
      @(negedge clk_sys);
    end
    `CHK("refused", r, c)
  endtask
  task automatic t_reset();
    `CHK("inBytes", 9'h020, inBytes)
    `CHK("inIoLast", 16'h02FF, inIoLast)
    `CHK("state", fsi_pkg::ST_INIT, commState)
    patt(3, 10'h000);
    patt(1, 10'h000);
    patt(0, 10'h000);
  endtask
  task automatic t_sizes();
    restrictSizes = 1'h1;
    inBytesCfg = 9'h040;
    outBytesCfg = 9'h080;
    pulse(sizeLoad);
    repeat (3) @(negedge clk_sys);
    `CHK("inBytes", 9'h040, inBytes)
    `CHK("inIoLast", 16'h03FF, inIoLast)
    `CHK("outIoLast", 16'h05FF, outIoLast)
    `CHK("outBytes", 9'h080, outBytes)
    mapOutDir = 1'h1;
    mapBitIdx = 12'h3FF;
    pulse(mapReq);
    `CHK("mapValid", 1'h1, mapValid)
    `CHK("mapIoNum", 16'h05FF, mapIoNum)
    mapBitIdx = 12'h400;
    pulse(mapReq);
    `CHK("mapValid", 1'h0, mapValid)
    mapOutDir = 1'h0;
    mapBitIdx = 12'h1FF;
    pulse(mapReq);
    `CHK("mapValid", 1'h1, mapValid)
    `CHK("mapIoNum", 16'h03FF, mapIoNum)
    mapBitIdx = 12'h200;
    pulse(mapReq);
    `CHK("mapValid", 1'h0, mapValid)
  endtask
  task automatic t_states();
    // with the enable low a master request must leave no trace
    clkEn = 1'h0;
    mreq(fsi_pkg::ST_PREOP, 4'h0);
    `CHK("state", fsi_pkg::ST_INIT, commState)
    clkEn = 1'h1;
    mreq(fsi_pkg::ST_PREOP, 4'h0);
    `CHK("svc", 4'h8, svc)
    patt(3, 10'h0C0);
    mreq(fsi_pkg::ST_SAFEOP, 4'h0);
    `CHK("svc", 4'hC, svc)
    patt(3, 10'h040);
    mreq(fsi_pkg::ST_OP, 4'h0);
    `CHK("svc", 4'hE, svc)
    patt(3, 10'h180);
  endtask
  task automatic t_errs();
    pulse(wdogExpire);
    patt(1, 10'h060);
    `CHK("state", fsi_pkg::ST_SAFEOP, commState)
    mreq(fsi_pkg::ST_OP, 4'h0);
    appReqState = fsi_pkg::ST_PREOP;
    pulse(appReqValid);
    patt(1, 10'h040);
    mreq(fsi_pkg::ST_INIT, 4'h0);
    mreq(fsi_pkg::ST_SAFEOP, 4'h1);
    patt(1, 10'h0C0);
    // an illegal size set must block the step past pre-operational
    inBytesCfg = 9'h030;
    pulse(sizeLoad);
    mreq(fsi_pkg::ST_PREOP, 4'h0);
    mreq(fsi_pkg::ST_SAFEOP, 4'h1);
    `CHK("state", fsi_pkg::ST_PREOP, commState)
    `CHK("errClass", fsi_pkg::ERR_INVALID, errClass)
    mreq(fsi_pkg::ST_PREOP, 4'h0);
    `CHK("errClass", fsi_pkg::ERR_NONE, errClass)
    appException = 1'h1;
    patt(1, 10'h180);
    appException = 1'h0;
    bootError = 1'h1;
    patt(1, 10'h0C0);
    bootError = 1'h0;
  endtask
  task automatic t_boot_link();
    mreq(fsi_pkg::ST_INIT, 4'h0);
    mreq(fsi_pkg::ST_BOOT, 4'h0);
    patt(3, 10'h0C0);
    mreq(fsi_pkg::ST_OP, 4'h1);
    mreq(fsi_pkg::ST_INIT, 4'h0);
    linkUp = 1'h1;
    patt(0, 10'h180);
    // a level here stands for traffic on every cycle
    rxActivity = 1'h1;
    patt(0, 10'h0C0);
    rxActivity = 1'h0;
  endtask
  task automatic t_fatal();
    pulse(fatalEvent);
    patt(2, 10'h180);
    patt(1, 10'h180);
    `CHK("svc", 4'h1, svc)
    `CHK("leds", 4'h7, leds)
    // after a fatal event requests are dropped silently and the state stays put
    mreq(fsi_pkg::ST_PREOP, 4'h0);
    `CHK("state", fsi_pkg::ST_INIT, commState)
  endtask
  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'h1;
    @(negedge clk_sys);
    t_reset();
    t_sizes();
    t_states();
    t_errs();
    t_boot_link();
    t_fatal();
    complete_run();
  end
endmodule

/* tb/fsi_master_model.sv */
`timescale 1ns/1ps
module fsi_master_model
(
  input wire logic clk_sys,
  output logic masterReqValid,
  output fsi_pkg::fsi_state_t masterReqState
);
  initial
  begin
    masterReqValid = 1'h0;
    masterReqState = fsi_pkg::ST_INIT;
  end
  // one-cycle request per transition, launched off the falling edge
  task automatic request(input fsi_pkg::fsi_state_t s);
    @(negedge clk_sys);
    masterReqValid = 1'h1;
    masterReqState = s;
    @(negedge clk_sys);
    masterReqValid = 1'h0;
    // released lines show the inverse so a stale value is never mistaken for a request
    masterReqState = fsi_pkg::fsi_state_t'(~s);
  endtask
endmodule
